/* File: include/srwd_pkg.sv */
// shared constants and state types for the supply reset and watchdog block
package srwd_pkg;

	// ==========================================================
	// clock and counter geometry
	localparam int SRWD_CLK_PERIOD_NS = 5; // 200 MHz reference clock
	localparam int SRWD_CNT_W = 28; // holds the longest period in cycles

	// ==========================================================
	// programmed times, in their own units
	localparam int SRWD_RST_DELAY_US = 2300; // reset delay, 1 nF setting
	localparam int SRWD_UPPER_US = 855000; // upper bound period, 47 nF
	localparam int SRWD_LOWER_US = 27600; // lower bound period, 47 nF
	localparam int SRWD_NS_PER_US = 1000;

	// ==========================================================
	// derived cycle counts: least times round up, longest round down
	localparam logic [SRWD_CNT_W-1:0] SRWD_RST_DELAY_CYC = SRWD_CNT_W'(
		(SRWD_RST_DELAY_US * SRWD_NS_PER_US + SRWD_CLK_PERIOD_NS - 1)
		/ SRWD_CLK_PERIOD_NS);
	localparam logic [SRWD_CNT_W-1:0] SRWD_UPPER_CYC = SRWD_CNT_W'(
		(SRWD_UPPER_US * SRWD_NS_PER_US) / SRWD_CLK_PERIOD_NS);
	localparam logic [SRWD_CNT_W-1:0] SRWD_LOWER_CYC = SRWD_CNT_W'(
		(SRWD_LOWER_US * SRWD_NS_PER_US + SRWD_CLK_PERIOD_NS - 1)
		/ SRWD_CLK_PERIOD_NS);

	// ==========================================================
	// counter and pin level constants
	localparam logic [SRWD_CNT_W-1:0] SRWD_CNT_ZERO = '0;
	localparam logic [SRWD_CNT_W-1:0] SRWD_CNT_ONE = SRWD_CNT_W'(1);
	localparam logic SRWD_PIN_ACTIVE_N = 1'b0; // output pulled low
	localparam logic SRWD_PIN_IDLE_N = 1'b1; // output released
	localparam logic SRWD_OE_ON = 1'b1;
	localparam logic SRWD_OE_OFF = 1'b0;
	localparam logic SRWD_KICK_RST = 1'b0; // synchroniser reset level
	localparam logic SRWD_FLAG_CLR = 1'b0;
	localparam logic SRWD_FLAG_SET = 1'b1;

	// ==========================================================
	// state types
	typedef enum logic [1:0] {SUP_LOW, SUP_DELAY, SUP_OK} srwd_sup_e;
	typedef enum logic [1:0] {WD_OFF, WD_RUN, WD_FAULT} srwd_wd_e;

endpackage : srwd_pkg

/* File: logic/srwd_delay_timer.sv */
// cycle-count delay timer: counts while run is high, flags its limit
`timescale 1ns/100ps
`default_nettype none

module srwd_delay_timer import srwd_pkg::*; (
	// clock, reset and enable
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	// control
	input wire logic run_i,
	input wire logic [SRWD_CNT_W-1:0] limit_i,
	// status
	output logic done_o
);

	// ==========================================================
	// count state
	logic [SRWD_CNT_W-1:0] count; // cycles spent running
	logic [SRWD_CNT_W-1:0] next_count;
	logic next_done;

	// next count: clear when idle, hold at the limit once reached
	always_comb begin
		next_count = count;
		if (!run_i) begin
			next_count = SRWD_CNT_ZERO;
		end else if (count != limit_i) begin
			next_count = count + SRWD_CNT_ONE;
		end
		// done only while still running, so a stop drops it at once
		next_done = run_i && (next_count == limit_i);
	end

	// register, frozen while the clock enable is low
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			count <= SRWD_CNT_ZERO; // [R14]
			done_o <= SRWD_FLAG_CLR;
		end else if (clk_en_i) begin
			count <= next_count;
			done_o <= next_done;
		end
	end

	// ==========================================================
	// checks
	chk_timer_limit_exact: assert property (@(posedge clock_i) // [R03]
		disable iff (sys_rst_i)
		done_o |-> (count == limit_i))
		else $error("timer done without count at limit");

endmodule : srwd_delay_timer

`default_nettype wire

/* File: logic/srwd_top.sv */
// supply reset generator and processor watchdog, top level
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Functional notes
// [R01] supply reset low while output is bad
// [R02] release reset after delay once output good
// [R03] reset delay is a block parameter
// [R04] disable input selects whether watchdog supervises
// [R05] disabled watchdog stops and releases fault
// [R06] mode input picks timeout or window mode
// [R07] low selects window, high selects timeout
// [R08] timeout: any kick edge clears, none faults
// [R09] window: falling edges too close or late fault
// [R10] fault held low for one reset delay
// [R11] supply undervoltage also releases the fault
// [R12] kick ignored and timer stopped during fault
// [R13] timeout and window bounds are parameters
// [R14] cycle counters, synced kick, synchronous clear

module srwd_top import srwd_pkg::*; #(
	// cycle counts, shortened freely in simulation
	parameter logic [SRWD_CNT_W-1:0] RESET_DELAY_SETTING =
		SRWD_RST_DELAY_CYC,
	parameter logic [SRWD_CNT_W-1:0] UPPER_BOUND_PERIOD = SRWD_UPPER_CYC,
	parameter logic [SRWD_CNT_W-1:0] LOWER_BOUND_PERIOD = SRWD_LOWER_CYC
) (
	// clock, reset and enable
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	// supply monitor: high while the regulated output is good
	input wire logic vout_good_i,
	// processor side controls
	input wire logic watchdog_kick_i,
	input wire logic watchdog_disable_i,
	input wire logic timeout_mode_i,
	// supply reset, open drain
	output logic supply_reset_n_o,
	output logic supply_reset_oe_o,
	// watchdog fault, open drain
	output logic watchdog_fault_n_o,
	output logic watchdog_fault_oe_o
);

	// ==========================================================
	// kick synchroniser and edge detect
	logic kick_meta; // first stage, read only by kick_sync
	logic kick_sync; // second stage, safe to use
	logic kick_prev; // delayed copy for edge detection
	logic next_kick_meta;
	logic next_kick_sync;
	logic next_kick_prev;
	logic kick_any; // either level change
	logic kick_fall; // falling edge only

	// next values of the synchroniser chain
	always_comb begin
		next_kick_meta = watchdog_kick_i;
		next_kick_sync = kick_meta;
		next_kick_prev = kick_sync;
	end

	// register the chain; the pin is asynchronous to clock_i
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			kick_meta <= SRWD_KICK_RST; // [R14]
			kick_sync <= SRWD_KICK_RST;
			kick_prev <= SRWD_KICK_RST;
		end else if (clk_en_i) begin
			kick_meta <= next_kick_meta; // [R14]
			kick_sync <= next_kick_sync;
			kick_prev <= next_kick_prev;
		end
	end

	// edges come from the settled stages only
	assign kick_any = kick_sync ^ kick_prev;
	assign kick_fall = kick_prev & ~kick_sync;

	// ==========================================================
	// supply reset state machine
	srwd_sup_e sup_state; // power-on reset progress
	srwd_sup_e next_sup_state;
	logic next_supply_reset_n;
	logic sup_done; // reset delay elapsed

	// next state: any loss of output restarts from the low state
	always_comb begin
		next_sup_state = sup_state;
		unique case (sup_state)
			SUP_LOW: begin
				if (vout_good_i) begin
					next_sup_state = SUP_DELAY; // [R02]
				end
			end
			SUP_DELAY: begin
				if (!vout_good_i) begin
					next_sup_state = SUP_LOW; // [R01]
				end else if (sup_done) begin
					next_sup_state = SUP_OK; // [R02]
				end
			end
			SUP_OK: begin
				if (!vout_good_i) begin
					next_sup_state = SUP_LOW; // [R01]
				end
			end
		endcase
		// output follows the next state so pin and state agree
		next_supply_reset_n = (next_sup_state == SUP_OK);
	end

	// register supply state and pin
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			sup_state <= SUP_LOW;
			supply_reset_n_o <= SRWD_PIN_ACTIVE_N;
			supply_reset_oe_o <= SRWD_OE_ON;
		end else if (clk_en_i) begin
			sup_state <= next_sup_state;
			supply_reset_n_o <= next_supply_reset_n;
			supply_reset_oe_o <= ~next_supply_reset_n;
		end
	end

	// reset delay timer, runs only while waiting to release
	srwd_delay_timer u_sup_timer (
		.clock_i (clock_i),
		.sys_rst_i (sys_rst_i),
		.clk_en_i (clk_en_i),
		.run_i (sup_state == SUP_DELAY), // [R02]
		.limit_i (RESET_DELAY_SETTING), // [R03]
		.done_o (sup_done)
	);

	// ==========================================================
	// watchdog state machine
	srwd_wd_e wd_state; // watchdog progress
	srwd_wd_e next_wd_state;
	logic [SRWD_CNT_W-1:0] wd_count; // cycles since last good kick
	logic [SRWD_CNT_W-1:0] next_wd_count;
	logic armed; // a falling edge already opened a window
	logic next_armed;
	logic next_fault_n;
	logic fault_done; // fault pulse has lasted one reset delay
	logic wd_stop; // supervision suspended
	logic wd_expire; // upper bound reached this cycle
	logic wd_early; // falling edge before lower bound
	logic wd_clear; // kick that satisfies the current mode

	// suspend on disable or whenever the supply reset is asserted
	assign wd_stop = watchdog_disable_i // [R04]
		|| !vout_good_i || (sup_state != SUP_OK); // [R11]
	assign wd_expire = (wd_count >= UPPER_BOUND_PERIOD - SRWD_CNT_ONE);
	// the count shows the spacing less one, so a gap of exactly the
	// lower bound is still legal and only shorter gaps fault
	assign wd_early = kick_fall && armed // [R09]
		&& (wd_count < LOWER_BOUND_PERIOD - SRWD_CNT_ONE); // [R13]
	// high on the mode pin is timeout, low is window
	assign wd_clear = timeout_mode_i ? kick_any : kick_fall; // [R07]

	// next state and count
	always_comb begin
		next_wd_state = wd_state;
		next_wd_count = wd_count;
		next_armed = armed;
		if (wd_stop) begin
			// stopped: counter cleared, no window history kept
			next_wd_state = WD_OFF; // [R05]
			next_wd_count = SRWD_CNT_ZERO;
			next_armed = SRWD_FLAG_CLR;
		end else begin
			unique case (wd_state)
				WD_OFF: begin
					// start timing from the moment supervision begins
					next_wd_state = WD_RUN; // [R04]
					next_wd_count = SRWD_CNT_ZERO;
					next_armed = SRWD_FLAG_CLR;
				end
				WD_RUN: begin
					if (timeout_mode_i) begin // [R06]
						// timeout mode: any level change restarts the count
						if (kick_any) begin
							next_wd_count = SRWD_CNT_ZERO; // [R08]
						end else if (wd_expire) begin
							next_wd_state = WD_FAULT; // [R08]
							next_wd_count = SRWD_CNT_ZERO;
						end else begin
							next_wd_count = wd_count + SRWD_CNT_ONE;
						end
					end else begin
						// window mode: only falling edges count
						if (wd_early) begin
							next_wd_state = WD_FAULT; // [R09]
							next_wd_count = SRWD_CNT_ZERO;
						end else if (kick_fall) begin
							next_wd_count = SRWD_CNT_ZERO; // [R09]
							next_armed = SRWD_FLAG_SET;
						end else if (wd_expire) begin
							next_wd_state = WD_FAULT; // [R09]
							next_wd_count = SRWD_CNT_ZERO;
						end else begin
							next_wd_count = wd_count + SRWD_CNT_ONE;
						end
					end
				end
				WD_FAULT: begin
					// kicks ignored, count held; rearm after the pulse
					next_wd_count = SRWD_CNT_ZERO; // [R12]
					next_armed = SRWD_FLAG_CLR;
					if (fault_done) begin
						next_wd_state = WD_RUN; // [R10]
					end
				end
			endcase
		end
		next_fault_n = (next_wd_state != WD_FAULT);
	end

	// register watchdog state and pin
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			wd_state <= WD_OFF;
			wd_count <= SRWD_CNT_ZERO; // [R14]
			armed <= SRWD_FLAG_CLR;
			watchdog_fault_n_o <= SRWD_PIN_IDLE_N;
			watchdog_fault_oe_o <= SRWD_OE_OFF;
		end else if (clk_en_i) begin
			wd_state <= next_wd_state;
			wd_count <= next_wd_count;
			armed <= next_armed;
			watchdog_fault_n_o <= next_fault_n;
			watchdog_fault_oe_o <= ~next_fault_n;
		end
	end

	// fault pulse length uses the same programmed reset delay
	srwd_delay_timer u_fault_timer (
		.clock_i (clock_i),
		.sys_rst_i (sys_rst_i),
		.clk_en_i (clk_en_i),
		.run_i (wd_state == WD_FAULT), // [R10]
		.limit_i (RESET_DELAY_SETTING),
		.done_o (fault_done)
	);

	// ==========================================================
	// checks
	chk_rst_on_bad: assert property (@(posedge clock_i) // [R01]
		disable iff (sys_rst_i)
		(clk_en_i && !vout_good_i) |=> !supply_reset_n_o)
		else $error("supply reset not asserted on bad output");

	chk_rst_after_delay: assert property (@(posedge clock_i) // [R02]
		disable iff (sys_rst_i)
		$rose(supply_reset_n_o) |-> ($past(sup_done)
			&& $past(sup_state) == SUP_DELAY))
		else $error("supply reset released before delay");

	chk_wd_disabled_idle: assert property (@(posedge clock_i) // [R05]
		disable iff (sys_rst_i)
		(clk_en_i && watchdog_disable_i) |=>
			(watchdog_fault_n_o && wd_count == SRWD_CNT_ZERO))
		else $error("disabled watchdog not idle");

	chk_timeout_kick_clr: assert property (@(posedge clock_i) // [R08]
		disable iff (sys_rst_i)
		(clk_en_i && !wd_stop && wd_state == WD_RUN && timeout_mode_i
			&& kick_any) |=>
			(wd_count == SRWD_CNT_ZERO && watchdog_fault_n_o))
		else $error("timeout kick did not clear watchdog");

	chk_upper_expire: assert property (@(posedge clock_i) // [R08]
		disable iff (sys_rst_i)
		(clk_en_i && !wd_stop && wd_state == WD_RUN && !wd_clear
			&& wd_count == UPPER_BOUND_PERIOD - SRWD_CNT_ONE) |=>
			!watchdog_fault_n_o)
		else $error("missing kick did not raise fault");

	chk_window_early: assert property (@(posedge clock_i) // [R09]
		disable iff (sys_rst_i)
		(clk_en_i && !wd_stop && wd_state == WD_RUN && !timeout_mode_i
			&& kick_fall && armed
			&& wd_count < LOWER_BOUND_PERIOD - SRWD_CNT_ONE) |=>
			!watchdog_fault_n_o)
		else $error("early falling edge did not raise fault");

	chk_fault_held: assert property (@(posedge clock_i) // [R10]
		disable iff (sys_rst_i)
		(clk_en_i && !wd_stop && wd_state == WD_FAULT && !fault_done)
			|=> (!watchdog_fault_n_o && !watchdog_fault_oe_o == 1'b0))
		else $error("fault pulse ended before reset delay");

	chk_fault_uv_release: assert property (@(posedge clock_i) // [R11]
		disable iff (sys_rst_i)
		(clk_en_i && !vout_good_i) |=> watchdog_fault_n_o)
		else $error("fault not released on undervoltage");

	chk_fault_kick_ignored: assert property (@(posedge clock_i) // [R12]
		disable iff (sys_rst_i)
		(wd_state == WD_FAULT) |=> (wd_count == SRWD_CNT_ZERO))
		else $error("watchdog count moved during fault");

endmodule : srwd_top

`default_nettype wire

/* File: test/srwd_cpu_model.sv */
// processor model that toggles the watchdog kick line at a set spacing
`timescale 1ns/100ps
`default_nettype none

module srwd_cpu_model (
	// clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// control from the bench
	input wire logic run_i,
	input wire logic [7:0] half_i,
	// kick line to the block
	output logic kick_o
);
	// ==========================================================
	// toggle timer
	logic [7:0] cnt; // cycles since the last level change

	// level changes only while running, half_i cycles apart, so falling
	// edges come 2*half_i apart; the bench picks the spacing per scenario
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			cnt <= 8'h00;
			kick_o <= 1'b0;
		end else if (run_i && (cnt + 8'h01 >= half_i)) begin
			cnt <= 8'h00;
			kick_o <= ~kick_o;
		end else begin
			cnt <= run_i ? cnt + 8'h01 : 8'h00;
		end
	end
endmodule : srwd_cpu_model
`default_nettype wire

/* File: test/srwd_top_test.sv */
// self-checking bench for the supply reset and watchdog block
`timescale 1ns/100ps
`default_nettype none

module srwd_top_test;
	import srwd_pkg::*;
	// ==========================================================
	// short simulation counts
	localparam int D = 20; // reset delay
	localparam int LB = 10; // window lower bound
	localparam int UB = 60; // upper bound
	logic clock_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic vout_good_i = 1'b0;
	logic wd_disable = 1'b0;
	logic tmode = 1'b1; // high selects timeout mode
	logic run = 1'b0;
	logic [7:0] half = 8'h03;
	logic clk_en = 1'b1; // freezes the whole block while low
	logic kick;
	logic rst_n, rst_oe, flt_n, flt_oe;
	int n_errors = 0;
	int n_checks = 0;
	int n;

	srwd_top #(.RESET_DELAY_SETTING(28'(D)), .UPPER_BOUND_PERIOD(28'(UB)),
		.LOWER_BOUND_PERIOD(28'(LB))) dut (.clock_i(clock_i),
		.sys_rst_i(sys_rst_i), .clk_en_i(clk_en), .vout_good_i(vout_good_i),
		.watchdog_kick_i(kick), .watchdog_disable_i(wd_disable),
		.timeout_mode_i(tmode), .supply_reset_n_o(rst_n),
		.supply_reset_oe_o(rst_oe), .watchdog_fault_n_o(flt_n),
		.watchdog_fault_oe_o(flt_oe));
	srwd_cpu_model cpu (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
		.run_i(run), .half_i(half), .kick_o(kick));

	// ==========================================================
	// clock, 5 ns period
	initial begin
		forever #2.5 clock_i = ~clock_i;
	end

	// compare one value and count the outcome
	task check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : check

	// edges until the fault output reads low, bounded by lim
	task to_fault(input int lim, output int k);
		k = 0;
		while (flt_n !== 1'b0 && k < lim) begin
			@(posedge clock_i);
			#1;
			k++;
		end
	endtask : to_fault

	// edges the fault pulse stays low
	task fault_width(output int k);
		k = 0;
		while (flt_n === 1'b0 && k < 1000) begin
			@(posedge clock_i);
			#1;
			k++;
		end
	endtask : fault_width

	// power-up: reset held for the programmed delay after output good
	task t_power;
		check(rst_n, 1'b0);
		check(rst_oe, 1'b1);
		check(flt_n, 1'b1);
		@(posedge clock_i);
		vout_good_i <= 1'b1;
		#1;
		n = 0;
		while (rst_n !== 1'b1 && n < 1000) begin
			@(posedge clock_i);
			#1;
			n++;
		end
		check(n, D + 2);
		check(rst_oe, 1'b0);
		$display("test power done");
	endtask : t_power

	// timeout mode: silence faults, kicks in the pulse are ignored
	task t_timeout;
		to_fault(UB + 8, n);
		check((n >= UB - 2) && (n <= UB + 4), 1'b1);
		check(flt_oe, 1'b1);
		run <= 1'b1; // kicks during the pulse must not shorten it
		fault_width(n);
		check(n, D + 1);
		to_fault(200, n);
		check(n, 200);
		$display("test timeout done");
	endtask : t_timeout

	// window mode: legal spacings, both bounds, too fast, then too slow
	task t_window;
		@(posedge clock_i);
		tmode <= 1'b0;
		half <= 8'h0a;
		to_fault(300, n);
		check(n, 300);
		@(posedge clock_i);
		half <= 8'h1e; // falling edges exactly the upper bound apart
		to_fault(200, n);
		check(n, 200);
		@(posedge clock_i);
		half <= 8'h05; // falling edges exactly the lower bound apart
		to_fault(100, n);
		check(n, 100);
		@(posedge clock_i);
		half <= 8'h03;
		to_fault(40, n);
		check(n < 40, 1'b1);
		fault_width(n);
		check(n, D + 1);
		run <= 1'b0;
		to_fault(UB + 8, n);
		check((n >= UB - 2) && (n <= UB + 4), 1'b1);
		$display("test window done");
	endtask : t_window

	// disable during a pulse releases the fault and stops the timer
	task t_disable;
		@(posedge clock_i);
		wd_disable <= 1'b1;
		repeat (2) @(posedge clock_i);
		#1;
		check(flt_n, 1'b1);
		to_fault(200, n);
		check(n, 200);
		$display("test disable done");
	endtask : t_disable

	// undervoltage in mid-pulse asserts reset and releases the fault
	task t_undervolt;
		@(posedge clock_i);
		wd_disable <= 1'b0;
		tmode <= 1'b1;
		to_fault(UB + 8, n);
		check(flt_n, 1'b0);
		@(posedge clock_i);
		vout_good_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		#1;
		check(rst_n, 1'b0);
		check(rst_oe, 1'b1);
		check(flt_n, 1'b1);
		check(flt_oe, 1'b0);
		$display("test undervolt done");
	endtask : t_undervolt

	// clock enable low in mid-delay holds the count for ten edges
	task t_freeze;
		@(posedge clock_i);
		vout_good_i <= 1'b1;
		repeat (5) @(posedge clock_i);
		clk_en <= 1'b0;
		repeat (10) @(posedge clock_i);
		clk_en <= 1'b1;
		#1;
		check(rst_n, 1'b0);
		n = 0;
		while (rst_n !== 1'b1 && n < 1000) begin
			@(posedge clock_i);
			#1;
			n++;
		end
		// delay of D + 2 edges, ten frozen, fifteen already spent
		check(n, D + 2 + 10 - 15);
		$display("test freeze done");
	endtask : t_freeze

	// verdict and end of run
	task test_done;
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done

	// ==========================================================
	// main sequence
	initial begin
		repeat (12) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		#1;
		t_power;
		t_timeout;
		t_window;
		t_disable;
		t_undervolt;
		t_freeze;
		test_done;
	end

	// hang guard, well past the 1300 or so cycles the tests need
	initial begin
		#(5 * 5000);
		n_errors++;
		test_done;
	end
endmodule : srwd_top_test
`default_nettype wire
